// ---- logic/ocr_pkg.sv ----
// Shared constants and types of the on-chip RAM ports
package ocr_pkg;

  // ************************************************************
  // Burst and response codes
  // ************************************************************
  localparam logic [1:0] BURST_INCR  = 2'h1;
  localparam logic [1:0] BURST_WRAP  = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Control/status port layout
  // ************************************************************
  localparam int          CSR_ADDR_W      = 5;
  localparam int          CSR_DATA_W      = 32;
  localparam int          CSR_STRB_W      = 4;
  localparam int          CSR_WORDS       = 8;
  localparam int          CSR_WORD_LSB    = 2;
  localparam int          CSR_IDX_W       = 3;
  localparam int          PROT_W          = 3;
  localparam int          PROT_NONSEC_BIT = 1;
  localparam int          PROT_INSTR_BIT  = 2;
  localparam logic [31:0] CSR_RESET_VAL   = 32'h0000_0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0] len;
    logic [2:0] size;
    logic [1:0] burst;
  } ocr_burst_type;

  typedef enum logic [2:0] {
    W_IDLE = 3'h1,
    W_DATA = 3'h2,
    W_RESP = 3'h4
  } ocr_wstate_type;

  typedef enum logic [1:0] {
    R_IDLE = 2'h1,
    R_DATA = 2'h2
  } ocr_rstate_type;

endpackage : ocr_pkg

// ---- logic/ocr_burst_addr.sv ----
// Next beat address of an incrementing or wrapping burst
`timescale 1ns/1ps
module ocr_burst_addr #(
  parameter int ADDR_W = 16
) (
  // Current beat
  input  wire logic [ADDR_W-1:0]  addr_i,
  input  wire ocr_pkg::ocr_burst_type burst_i,
  // Following beat
  output logic [ADDR_W-1:0]       next_o
);

  logic [ADDR_W-1:0] step;
  logic [ADDR_W-1:0] span_mask;
  logic [ADDR_W-1:0] sum;

  always_comb begin
    step      = ADDR_W'(1) << burst_i.size;
    // Wrap lengths are powers of two, so the span is a clean mask
    span_mask = ((ADDR_W'(burst_i.len) + ADDR_W'(1)) << burst_i.size) - ADDR_W'(1);
    // Unaligned first beat: later beats fall on size boundaries
    sum       = (addr_i & ~(step - ADDR_W'(1))) + step;
    if (burst_i.burst == ocr_pkg::BURST_WRAP) begin
      next_o = (addr_i & ~span_mask) | (sum & span_mask);
    end else begin
      next_o = sum;
    end
  end

endmodule : ocr_burst_addr

// ---- logic/ocr_axi_ram.sv ----
// On-chip RAM with a burst memory port and a control/status port
`timescale 1ns/1ps

// Notes on behaviour
// - CSR port serves only non-secure data accesses
// - CSR handshakes run on their own clock
// - CSR domain reset by its own reset
// - CSR writes update only strobed byte lanes
// - Write address ready only when acceptable
// - Read address ready only when acceptable
// - Memory port supports incrementing and wrapping bursts
// - First beat given, later beats computed
// - Eight-bit length sets number of beats
// - Size field sets bytes per beat
// - Memory writes touch only strobed bytes
// - Write response carries the write tag
// - Read beats carry the read tag
// - Reset request gates new bursts and write beats, not a read burst in flight
// - Memory port runs on its own clock
module ocr_axi_ram #(
  parameter int TAG_BIT_WIDTH     = 4,
  parameter int ADDRESS_BIT_WIDTH = 16,
  parameter int DATA_BIT_WIDTH    = 32,
  parameter int MEM_WORDS         = 1024
) (
  // Memory port clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         reset_req_i,
  // Memory port write address
  input  wire logic [TAG_BIT_WIDTH-1:0]     mem_awid_i,
  input  wire logic [ADDRESS_BIT_WIDTH-1:0] mem_awaddr_i,
  input  wire logic [7:0]                   mem_awlen_i,
  input  wire logic [2:0]                   mem_awsize_i,
  input  wire logic [1:0]                   mem_awburst_i,
  input  wire logic                         mem_awvalid_i,
  output logic                              mem_awready_o,
  // Memory port write data and response
  input  wire logic [DATA_BIT_WIDTH-1:0]    mem_wdata_i,
  input  wire logic [DATA_BIT_WIDTH/8-1:0]  mem_wstrb_i,
  input  wire logic                         mem_wlast_i,
  input  wire logic                         mem_wvalid_i,
  output logic                              mem_wready_o,
  output logic [TAG_BIT_WIDTH-1:0]          mem_bid_o,
  output logic [1:0]                        mem_bresp_o,
  output logic                              mem_bvalid_o,
  input  wire logic                         mem_bready_i,
  // Memory port read address
  input  wire logic [TAG_BIT_WIDTH-1:0]     mem_arid_i,
  input  wire logic [ADDRESS_BIT_WIDTH-1:0] mem_araddr_i,
  input  wire logic [7:0]                   mem_arlen_i,
  input  wire logic [2:0]                   mem_arsize_i,
  input  wire logic [1:0]                   mem_arburst_i,
  input  wire logic                         mem_arvalid_i,
  output logic                              mem_arready_o,
  // Memory port read data
  output logic [TAG_BIT_WIDTH-1:0]          mem_rid_o,
  output logic [DATA_BIT_WIDTH-1:0]         mem_rdata_o,
  output logic [1:0]                        mem_rresp_o,
  output logic                              mem_rlast_o,
  output logic                              mem_rvalid_o,
  input  wire logic                         mem_rready_i,
  // Control/status clock and reset
  input  wire logic                         csr_clk_i,
  input  wire logic                         csr_rst_i,
  // Control/status write
  input  wire logic [4:0]                   csr_awaddr_i,
  input  wire logic [2:0]                   csr_awprot_i,
  input  wire logic                         csr_awvalid_i,
  output logic                              csr_awready_o,
  input  wire logic [31:0]                  csr_wdata_i,
  input  wire logic [3:0]                   csr_wstrb_i,
  input  wire logic                         csr_wvalid_i,
  output logic                              csr_wready_o,
  output logic [1:0]                        csr_bresp_o,
  output logic                              csr_bvalid_o,
  input  wire logic                         csr_bready_i,
  // Control/status read
  input  wire logic [4:0]                   csr_araddr_i,
  input  wire logic [2:0]                   csr_arprot_i,
  input  wire logic                         csr_arvalid_i,
  output logic                              csr_arready_o,
  output logic [31:0]                       csr_rdata_o,
  output logic [1:0]                        csr_rresp_o,
  output logic                              csr_rvalid_o,
  input  wire logic                         csr_rready_i
);

  localparam int LANES = DATA_BIT_WIDTH / 8;
  localparam int LSB   = $clog2(LANES);
  localparam int IDX_W = $clog2(MEM_WORDS);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [DATA_BIT_WIDTH-1:0] mem_q [MEM_WORDS];

  // ************************************************************
  // Write channel
  // ************************************************************
  ocr_pkg::ocr_wstate_type        w_state_q, w_state_d;
  ocr_pkg::ocr_burst_type         w_cmd_q, w_cmd_d;
  logic [ADDRESS_BIT_WIDTH-1:0]   w_addr_q, w_addr_d, w_next;
  logic [TAG_BIT_WIDTH-1:0]       w_id_q, w_id_d;
  logic [7:0]                     w_cnt_q, w_cnt_d;
  logic                           w_beat;

  ocr_burst_addr #(.ADDR_W(ADDRESS_BIT_WIDTH)) u_waddr (
    .addr_i  (w_addr_q),
    .burst_i (w_cmd_q),
    .next_o  (w_next)
  );

  always_comb begin
    w_state_d     = w_state_q;
    w_cmd_d       = w_cmd_q;
    w_addr_d      = w_addr_q;
    w_id_d        = w_id_q;
    w_cnt_d       = w_cnt_q;
    w_beat        = 1'b0;
    mem_awready_o = 1'b0;
    mem_wready_o  = 1'b0;
    case (w_state_q)
      ocr_pkg::W_IDLE: begin
        // Held off while the memory clock is gated
        mem_awready_o = !reset_req_i;
        if (mem_awvalid_i && !reset_req_i) begin
          w_cmd_d   = '{len: mem_awlen_i, size: mem_awsize_i, burst: mem_awburst_i};
          w_addr_d  = mem_awaddr_i;
          w_id_d    = mem_awid_i;
          w_cnt_d   = 8'h00;
          w_state_d = ocr_pkg::W_DATA;
        end
      end
      ocr_pkg::W_DATA: begin
        mem_wready_o = !reset_req_i;
        if (mem_wvalid_i && !reset_req_i) begin
          w_beat   = 1'b1;
          w_addr_d = w_next;
          w_cnt_d  = w_cnt_q + 8'h01;
          // Burst ends on the beat count; the last flag is not trusted
          if (w_cnt_q == w_cmd_q.len) begin
            w_state_d = ocr_pkg::W_RESP;
          end
        end
      end
      ocr_pkg::W_RESP: begin
        if (mem_bready_i) begin
          w_state_d = ocr_pkg::W_IDLE;
        end
      end
      default: w_state_d = ocr_pkg::W_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      w_state_q <= ocr_pkg::W_IDLE;
      w_cmd_q   <= '0;
      w_addr_q  <= '0;
      w_id_q    <= '0;
      w_cnt_q   <= 8'h00;
    end else begin
      w_state_q <= w_state_d;
      w_cmd_q   <= w_cmd_d;
      w_addr_q  <= w_addr_d;
      w_id_q    <= w_id_d;
      w_cnt_q   <= w_cnt_d;
    end
  end

  // Byte lanes written only where strobed; no write while gated
  always_ff @(posedge ref_clk_i) begin
    for (int b = 0; b < LANES; b++) begin
      if (w_beat && mem_wstrb_i[b]) begin
        mem_q[w_addr_q[LSB +: IDX_W]][8*b +: 8] <= mem_wdata_i[8*b +: 8];
      end
    end
  end

  assign mem_bvalid_o = (w_state_q == ocr_pkg::W_RESP);
  assign mem_bid_o    = w_id_q;
  assign mem_bresp_o  = ocr_pkg::RESP_OKAY;

  // ************************************************************
  // Read channel
  // ************************************************************
  ocr_pkg::ocr_rstate_type        r_state_q, r_state_d;
  ocr_pkg::ocr_burst_type         r_cmd_q, r_cmd_d;
  logic [ADDRESS_BIT_WIDTH-1:0]   r_addr_q, r_addr_d, r_next;
  logic [TAG_BIT_WIDTH-1:0]       r_id_q, r_id_d;
  logic [7:0]                     r_cnt_q, r_cnt_d;
  logic [DATA_BIT_WIDTH-1:0]      r_data_q, r_data_d;

  ocr_burst_addr #(.ADDR_W(ADDRESS_BIT_WIDTH)) u_raddr (
    .addr_i  (r_addr_q),
    .burst_i (r_cmd_q),
    .next_o  (r_next)
  );

  always_comb begin
    r_state_d     = r_state_q;
    r_cmd_d       = r_cmd_q;
    r_addr_d      = r_addr_q;
    r_id_d        = r_id_q;
    r_cnt_d       = r_cnt_q;
    r_data_d      = r_data_q;
    mem_arready_o = 1'b0;
    case (r_state_q)
      ocr_pkg::R_IDLE: begin
        mem_arready_o = !reset_req_i;
        if (mem_arvalid_i && !reset_req_i) begin
          r_cmd_d   = '{len: mem_arlen_i, size: mem_arsize_i, burst: mem_arburst_i};
          r_addr_d  = mem_araddr_i;
          r_id_d    = mem_arid_i;
          r_cnt_d   = 8'h00;
          r_data_d  = mem_q[mem_araddr_i[LSB +: IDX_W]];
          r_state_d = ocr_pkg::R_DATA;
        end
      end
      ocr_pkg::R_DATA: begin
        if (mem_rready_i) begin
          if (mem_rlast_o) begin
            r_state_d = ocr_pkg::R_IDLE;
          end else begin
            // Prefetch keeps one beat per cycle under a ready manager
            r_addr_d = r_next;
            r_cnt_d  = r_cnt_q + 8'h01;
            r_data_d = mem_q[r_next[LSB +: IDX_W]];
          end
        end
      end
      default: r_state_d = ocr_pkg::R_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      r_state_q <= ocr_pkg::R_IDLE;
      r_cmd_q   <= '0;
      r_addr_q  <= '0;
      r_id_q    <= '0;
      r_cnt_q   <= 8'h00;
      r_data_q  <= '0;
    end else begin
      r_state_q <= r_state_d;
      r_cmd_q   <= r_cmd_d;
      r_addr_q  <= r_addr_d;
      r_id_q    <= r_id_d;
      r_cnt_q   <= r_cnt_d;
      r_data_q  <= r_data_d;
    end
  end

  assign mem_rvalid_o = (r_state_q == ocr_pkg::R_DATA);
  assign mem_rdata_o  = r_data_q;
  assign mem_rid_o    = r_id_q;
  assign mem_rlast_o  = (r_cnt_q == r_cmd_q.len);
  assign mem_rresp_o  = ocr_pkg::RESP_OKAY;

  // ************************************************************
  // Control/status port
  // ************************************************************
  logic [31:0]                      csr_regs_q [ocr_pkg::CSR_WORDS];
  logic [31:0]                      csr_regs_d [ocr_pkg::CSR_WORDS];
  logic                             csr_bvalid_q, csr_bvalid_d;
  logic [1:0]                       csr_bresp_q, csr_bresp_d;
  logic                             csr_rvalid_q, csr_rvalid_d;
  logic [1:0]                       csr_rresp_q, csr_rresp_d;
  logic [31:0]                      csr_rdata_q, csr_rdata_d;
  logic                             csr_wr_hs, csr_wr_ok, csr_rd_hs, csr_rd_ok;
  logic [ocr_pkg::CSR_IDX_W-1:0]    csr_widx, csr_ridx;

  // Address and data taken together, so no half write is ever held
  assign csr_wr_hs     = csr_awvalid_i && csr_wvalid_i && !csr_bvalid_q;
  assign csr_awready_o = csr_wr_hs;
  assign csr_wready_o  = csr_wr_hs;
  assign csr_rd_hs     = csr_arvalid_i && !csr_rvalid_q;
  assign csr_arready_o = !csr_rvalid_q;
  assign csr_wr_ok     = csr_awprot_i[ocr_pkg::PROT_NONSEC_BIT] && !csr_awprot_i[ocr_pkg::PROT_INSTR_BIT];
  assign csr_rd_ok     = csr_arprot_i[ocr_pkg::PROT_NONSEC_BIT] && !csr_arprot_i[ocr_pkg::PROT_INSTR_BIT];
  assign csr_widx      = csr_awaddr_i[ocr_pkg::CSR_WORD_LSB +: ocr_pkg::CSR_IDX_W];
  assign csr_ridx      = csr_araddr_i[ocr_pkg::CSR_WORD_LSB +: ocr_pkg::CSR_IDX_W];

  always_comb begin
    csr_regs_d   = csr_regs_q;
    csr_bvalid_d = csr_bvalid_q && !csr_bready_i;
    csr_bresp_d  = csr_bresp_q;
    csr_rvalid_d = csr_rvalid_q && !csr_rready_i;
    csr_rresp_d  = csr_rresp_q;
    csr_rdata_d  = csr_rdata_q;
    if (csr_wr_hs) begin
      csr_bvalid_d = 1'b1;
      csr_bresp_d  = csr_wr_ok ? ocr_pkg::RESP_OKAY : ocr_pkg::RESP_SLVERR;
      for (int b = 0; b < ocr_pkg::CSR_STRB_W; b++) begin
        if (csr_wr_ok && csr_wstrb_i[b]) begin
          csr_regs_d[csr_widx][8*b +: 8] = csr_wdata_i[8*b +: 8];
        end
      end
    end
    if (csr_rd_hs) begin
      csr_rvalid_d = 1'b1;
      csr_rresp_d  = csr_rd_ok ? ocr_pkg::RESP_OKAY : ocr_pkg::RESP_SLVERR;
      csr_rdata_d  = csr_rd_ok ? csr_regs_q[csr_ridx] : 32'h0000_0000;
    end
  end

  always_ff @(posedge csr_clk_i) begin
    if (csr_rst_i) begin
      for (int i = 0; i < ocr_pkg::CSR_WORDS; i++) begin
        csr_regs_q[i] <= ocr_pkg::CSR_RESET_VAL;
      end
      csr_bvalid_q <= 1'b0;
      csr_bresp_q  <= 2'h0;
      csr_rvalid_q <= 1'b0;
      csr_rresp_q  <= 2'h0;
      csr_rdata_q  <= 32'h0000_0000;
    end else begin
      csr_regs_q   <= csr_regs_d;
      csr_bvalid_q <= csr_bvalid_d;
      csr_bresp_q  <= csr_bresp_d;
      csr_rvalid_q <= csr_rvalid_d;
      csr_rresp_q  <= csr_rresp_d;
      csr_rdata_q  <= csr_rdata_d;
    end
  end

  assign csr_bvalid_o = csr_bvalid_q;
  assign csr_bresp_o  = csr_bresp_q;
  assign csr_rvalid_o = csr_rvalid_q;
  assign csr_rresp_o  = csr_rresp_q;
  assign csr_rdata_o  = csr_rdata_q;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [TAG_BIT_WIDTH-1:0] chk_awid_q;
  logic [TAG_BIT_WIDTH-1:0] chk_arid_q;
  logic [8:0]               chk_rbeats_q;
  logic [7:0]               chk_arlen_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      chk_awid_q   <= '0;
      chk_arid_q   <= '0;
      chk_rbeats_q <= 9'h000;
      chk_arlen_q  <= 8'h00;
    end else begin
      if (mem_awvalid_i && mem_awready_o) begin
        chk_awid_q <= mem_awid_i;
      end
      if (mem_arvalid_i && mem_arready_o) begin
        chk_arid_q   <= mem_arid_i;
        chk_arlen_q  <= mem_arlen_i;
        chk_rbeats_q <= 9'h000;
      end else if (mem_rvalid_o && mem_rready_i) begin
        chk_rbeats_q <= chk_rbeats_q + 9'h001;
      end
    end
  end

  property p_csr_prot;
    @(posedge csr_clk_i) disable iff (csr_rst_i)
      (csr_wr_hs && !csr_awprot_i[ocr_pkg::PROT_NONSEC_BIT]) |=> (csr_bvalid_o && csr_bresp_o == ocr_pkg::RESP_SLVERR);
  endproperty
  a_csr_prot: assert property (p_csr_prot) else $error("secure csr write not refused");

  property p_csr_bhold;
    @(posedge csr_clk_i) disable iff (csr_rst_i)
      (csr_bvalid_o && !csr_bready_i) |=> (csr_bvalid_o && $stable(csr_bresp_o));
  endproperty
  a_csr_bhold: assert property (p_csr_bhold) else $error("csr write response dropped");

  property p_csr_reset;
    @(posedge csr_clk_i) csr_rst_i |=> (!csr_bvalid_o && !csr_rvalid_o && csr_regs_q[0] == ocr_pkg::CSR_RESET_VAL);
  endproperty
  a_csr_reset: assert property (p_csr_reset) else $error("csr domain not reset");

  property p_csr_lane;
    @(posedge csr_clk_i) disable iff (csr_rst_i)
      (csr_wr_hs && csr_widx == 3'h1 && !csr_wstrb_i[1]) |=> $stable(csr_regs_q[1][15:8]);
  endproperty
  a_csr_lane: assert property (p_csr_lane) else $error("unstrobed csr lane changed");

  property p_aw_busy;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (mem_awvalid_i && mem_awready_o) |=> !mem_awready_o ##1 !mem_awready_o;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("write address accepted mid burst");

  property p_ar_busy;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (mem_arvalid_i && mem_arready_o) |=> (mem_rvalid_o && !mem_arready_o);
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read address accepted mid burst");

  property p_bid;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mem_bvalid_o |-> (mem_bid_o == chk_awid_q);
  endproperty
  a_bid: assert property (p_bid) else $error("write response tag wrong");

  property p_rid;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mem_rvalid_o |-> (mem_rid_o == chk_arid_q);
  endproperty
  a_rid: assert property (p_rid) else $error("read beat tag wrong");

  property p_rlast;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      mem_rvalid_o |-> (mem_rlast_o == (chk_rbeats_q == {1'b0, chk_arlen_q}));
  endproperty
  a_rlast: assert property (p_rlast) else $error("read last on wrong beat");

  property p_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      reset_req_i |-> (!mem_awready_o && !mem_arready_o && !mem_wready_o);
  endproperty
  a_gate: assert property (p_gate) else $error("memory accessed while gated");

  property p_wrap;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (mem_rvalid_o && r_cmd_q.burst == ocr_pkg::BURST_WRAP && r_cmd_q.len == 8'h03 && r_cmd_q.size == 3'h2)
        |-> (r_next[ADDRESS_BIT_WIDTH-1:4] == r_addr_q[ADDRESS_BIT_WIDTH-1:4]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap burst left its window");

endmodule : ocr_axi_ram

// ---- bench/ocr_mgr_model.sv ----
// Manager-side model that accepts memory-port responses
`timescale 1ns/1ps
module ocr_mgr_model (
  // Clock, reset and pace
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic slow_i,
  // Response acceptance
  output logic      ready_o
);
  logic ready_q;
  logic ready_d;
  // Slow pace stalls every other cycle, so answers must stand
  always_comb ready_d = slow_i ? ~ready_q : 1'h1;
  always_ff @(posedge ref_clk_i) ready_q <= sys_rst_i ? 1'h0 : ready_d;
  assign ready_o = ready_q;
endmodule : ocr_mgr_model

// ---- bench/ocr_axi_ram_test.sv ----
// Self-checking bench of the on-chip RAM ports
`timescale 1ns/1ps
module ocr_axi_ram_test;
  // ************************************************************
  // Signals and burst table
  // ************************************************************
  localparam logic [1:0] INC = ocr_pkg::BURST_INCR;
  localparam logic [1:0] WRP = ocr_pkg::BURST_WRAP;
  localparam logic [1:0] OK = ocr_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ocr_pkg::RESP_SLVERR;
  typedef struct packed {
    logic [3:0]  id;
    logic [15:0] addr;
    logic [7:0]  len;
    logic [2:0]  sz;
    logic [1:0]  bt;
    logic [3:0]  strb;
    logic [8:0]  beats;
  } ocr_row_type;
  logic        ref_clk_i = '0, sys_rst_i = 1'h1, reset_req_i = '0, csr_clk_i = '0, csr_rst_i = 1'h1, slow = '0;
  logic [3:0]  mem_awid_i = '0, mem_arid_i = '0, mem_wstrb_i = '0, csr_wstrb_i = '0, mem_bid_o, mem_rid_o;
  logic [15:0] mem_awaddr_i = '0, mem_araddr_i = '0;
  logic [7:0]  mem_awlen_i = '0, mem_arlen_i = '0, ref_mem [0:4095];
  logic [2:0]  mem_awsize_i = '0, mem_arsize_i = '0, csr_awprot_i = '0, csr_arprot_i = '0;
  logic [1:0]  mem_awburst_i = '0, mem_arburst_i = '0, mem_bresp_o, mem_rresp_o, csr_bresp_o, csr_rresp_o;
  logic [31:0] mem_wdata_i = '0, csr_wdata_i = '0, mem_rdata_o, csr_rdata_o, sr_data, cr_data;
  logic [4:0]  csr_awaddr_i = '0, csr_araddr_i = '0;
  logic [3:0]  sb_id, sr_id;
  logic [1:0]  sb_resp, sr_resp, cb_resp, cr_resp;
  logic        mem_awvalid_i = '0, mem_wlast_i = '0, mem_wvalid_i = '0, mem_arvalid_i = '0, sr_last;
  logic        csr_awvalid_i = '0, csr_wvalid_i = '0, csr_bready_i = '0, csr_arvalid_i = '0, csr_rready_i = '0;
  logic        mem_awready_o, mem_wready_o, mem_bvalid_o, mem_bready_i, mem_arready_o, mem_rlast_o, mem_rvalid_o;
  logic        mem_rready_i, csr_awready_o, csr_wready_o, csr_bvalid_o, csr_arready_o, csr_rvalid_o;
  int          bad_count = 0;
  int          n_checks = 0;
  ocr_row_type rows [0:7] = '{'{4'h1, 16'h0010, 8'h00, 3'h2, INC, 4'hf, 9'h001},
    '{4'h2, 16'h0010, 8'h03, 3'h2, INC, 4'h5, 9'h004}, '{4'h3, 16'h0108, 8'h03, 3'h2, WRP, 4'hf, 9'h004},
    '{4'h4, 16'h0206, 8'h07, 3'h1, WRP, 4'hf, 9'h008}, '{4'h5, 16'h0301, 8'h04, 3'h0, INC, 4'hf, 9'h005},
    '{4'h6, 16'h0c00, 8'hff, 3'h2, INC, 4'hf, 9'h100}, '{4'h7, 16'h0a3c, 8'h0f, 3'h2, WRP, 4'ha, 9'h010},
    '{4'h8, 16'h0402, 8'h02, 3'h2, INC, 4'hf, 9'h003}};

  initial forever #20 ref_clk_i = ~ref_clk_i;
  // Unrelated period for the control/status domain
  initial forever #17 csr_clk_i = ~csr_clk_i;
  assign mem_rready_i = mem_bready_i;

  ocr_axi_ram i_dut (.ref_clk_i, .sys_rst_i, .reset_req_i, .mem_awid_i, .mem_awaddr_i, .mem_awlen_i, .mem_awsize_i,
    .mem_awburst_i, .mem_awvalid_i, .mem_awready_o, .mem_wdata_i, .mem_wstrb_i, .mem_wlast_i, .mem_wvalid_i,
    .mem_wready_o, .mem_bid_o, .mem_bresp_o, .mem_bvalid_o, .mem_bready_i, .mem_arid_i, .mem_araddr_i, .mem_arlen_i,
    .mem_arsize_i, .mem_arburst_i, .mem_arvalid_i, .mem_arready_o, .mem_rid_o, .mem_rdata_o, .mem_rresp_o,
    .mem_rlast_o, .mem_rvalid_o, .mem_rready_i, .csr_clk_i, .csr_rst_i, .csr_awaddr_i, .csr_awprot_i, .csr_awvalid_i,
    .csr_awready_o, .csr_wdata_i, .csr_wstrb_i, .csr_wvalid_i, .csr_wready_o, .csr_bresp_o, .csr_bvalid_o,
    .csr_bready_i, .csr_araddr_i, .csr_arprot_i, .csr_arvalid_i, .csr_arready_o, .csr_rdata_o, .csr_rresp_o,
    .csr_rvalid_o, .csr_rready_i);
  ocr_mgr_model i_mgr (.ref_clk_i, .sys_rst_i, .slow_i(slow), .ready_o(mem_bready_i));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  function automatic logic [15:0] nxt(input ocr_row_type r, input logic [15:0] a);
    logic [15:0] n;
    n = (a & ~((16'h1 << r.sz) - 16'h1)) + (16'h1 << r.sz);
    if (r.bt == WRP && (n & (((r.len + 16'h1) << r.sz) - 16'h1)) == 16'h0) n = n - ((r.len + 16'h1) << r.sz);
    return n;
  endfunction : nxt

  function automatic logic [3:0] lanes(input logic [15:0] a, input logic [2:0] sz);
    return sz == 3'h0 ? 4'h1 << a[1:0] : sz == 3'h1 ? 4'h3 << {a[1], 1'h0} : 4'hf;
  endfunction : lanes

  // Handshake k seen at the falling edge, answers snapped there
  task automatic wait_hs(input int k);
    logic [8:0] hv;
    do begin
      if (k < 5) @(negedge ref_clk_i);
      else @(negedge csr_clk_i);
      hv = {csr_rvalid_o, csr_arready_o, csr_bvalid_o, csr_awready_o & csr_wready_o, mem_rvalid_o & mem_rready_i,
            mem_arready_o, mem_bvalid_o & mem_bready_i, mem_wready_o, mem_awready_o};
      {sb_id, sb_resp, sr_id, sr_data, sr_resp, sr_last, cb_resp, cr_data, cr_resp} = {mem_bid_o, mem_bresp_o,
        mem_rid_o, mem_rdata_o, mem_rresp_o, mem_rlast_o, csr_bresp_o, csr_rdata_o, csr_rresp_o};
      if (k < 5) @(posedge ref_clk_i);
      else @(posedge csr_clk_i);
    end while (hv[k] !== 1'h1);
  endtask : wait_hs

  task automatic mem_wr(input ocr_row_type r);
    logic [15:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    a = r.addr;
    {mem_awid_i, mem_awaddr_i, mem_awlen_i, mem_awsize_i, mem_awburst_i, mem_awvalid_i} <=
      {r.id, r.addr, r.len, r.sz, r.bt, 1'h1};
    wait_hs(0);
    mem_awvalid_i <= 1'h0;
    for (int i = 0; i <= r.len; i++) begin
      s = r.strb & lanes(a, r.sz);
      d = {r.id, 12'h5a3, a};
      {mem_wdata_i, mem_wstrb_i, mem_wlast_i, mem_wvalid_i} <= {d, s, i == r.len, 1'h1};
      wait_hs(1);
      for (int b = 0; b < 4; b++) if (s[b]) ref_mem[{a[11:2], 2'(b)}] = d[8*b+:8];
      a = nxt(r, a);
    end
    mem_wvalid_i <= 1'h0;
    wait_hs(2);
    cmp(sb_id, r.id);
    cmp(sb_resp, OK);
  endtask : mem_wr

  task automatic mem_rd(input ocr_row_type r);
    logic [15:0] a;
    logic [31:0] e;
    logic [31:0] mk;
    int          n;
    a = r.addr;
    n = 0;
    {mem_arid_i, mem_araddr_i, mem_arlen_i, mem_arsize_i, mem_arburst_i, mem_arvalid_i} <=
      {r.id, r.addr, r.len, r.sz, r.bt, 1'h1};
    wait_hs(3);
    mem_arvalid_i <= 1'h0;
    do begin
      wait_hs(4);
      for (int b = 0; b < 4; b++) begin
        e[8*b+:8] = ref_mem[{a[11:2], 2'(b)}];
        mk[8*b+:8] = {8{|(lanes(a, r.sz) >> b & 4'h1) && !$isunknown(e[8*b+:8])}};
      end
      cmp(sr_data & mk, e & mk);
      cmp(sr_id, r.id);
      cmp({sr_resp, sr_last}, {OK, n == r.len});
      a = nxt(r, a);
      n++;
    end while (sr_last !== 1'h1 && n < 300);
    cmp(n, r.beats);
  endtask : mem_rd

  task automatic csr_wr(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [2:0] p,
                        input logic [1:0] er);
    @(posedge csr_clk_i);
    {csr_awaddr_i, csr_awprot_i, csr_wdata_i, csr_wstrb_i, csr_awvalid_i, csr_wvalid_i, csr_bready_i} <=
      {ad, p, d, s, 3'h7};
    wait_hs(5);
    {csr_awvalid_i, csr_wvalid_i} <= 2'h0;
    wait_hs(6);
    csr_bready_i <= 1'h0;
    cmp(cb_resp, er);
  endtask : csr_wr

  task automatic csr_rd(input logic [4:0] ad, input logic [2:0] p, input logic [31:0] ed, input logic [1:0] er);
    @(posedge csr_clk_i);
    {csr_araddr_i, csr_arprot_i, csr_arvalid_i, csr_rready_i} <= {ad, p, 2'h3};
    wait_hs(7);
    csr_arvalid_i <= 1'h0;
    wait_hs(8);
    csr_rready_i <= 1'h0;
    cmp({cr_data, cr_resp}, {ed, er});
  endtask : csr_rd

  // ************************************************************
  // Sequence and watchdog
  // ************************************************************
  initial begin
    repeat (4) @(posedge ref_clk_i);
    {sys_rst_i, csr_rst_i} <= 2'h0;
    @(negedge ref_clk_i);
    cmp({mem_bvalid_o, mem_rvalid_o, mem_awready_o, csr_arready_o, csr_bvalid_o}, 5'h6);
    @(posedge ref_clk_i);
    foreach (rows[j]) begin
      slow <= j[0];
      mem_wr(rows[j]);
      mem_rd(rows[j]);
    end
    reset_req_i <= 1'h1;
    @(negedge ref_clk_i);
    cmp({mem_awready_o, mem_arready_o, mem_wready_o}, 3'h0);
    @(posedge ref_clk_i);
    reset_req_i <= 1'h0;
    csr_wr(5'h04, 32'h11223344, 4'hf, 3'h2, OK);
    csr_wr(5'h07, 32'haabbccdd, 4'h5, 3'h3, OK);
    csr_rd(5'h04, 3'h2, 32'h11bb33dd, OK);
    csr_wr(5'h04, 32'h00000000, 4'hf, 3'h0, ER);
    csr_wr(5'h04, 32'h00000000, 4'hf, 3'h6, ER);
    csr_rd(5'h04, 3'h6, 32'h00000000, ER);
    csr_rd(5'h04, 3'h2, 32'h11bb33dd, OK);
    csr_wr(5'h1f, 32'h5a5a0f0f, 4'hf, 3'h2, OK);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    @(negedge ref_clk_i);
    cmp({mem_bvalid_o, mem_rvalid_o, mem_wready_o, mem_arready_o}, 4'h1);
    csr_rd(5'h1c, 3'h2, 32'h5a5a0f0f, OK);
    @(posedge ref_clk_i);
    mem_rd(rows[1]);
    @(posedge csr_clk_i);
    csr_rst_i <= 1'h1;
    repeat (2) @(posedge csr_clk_i);
    csr_rst_i <= 1'h0;
    csr_rd(5'h04, 3'h2, 32'h00000000, OK);
    @(posedge ref_clk_i);
    mem_rd(rows[2]);
    stop_test();
  end

  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
endmodule : ocr_axi_ram_test
